/* File: rtl/irqf_top.sv */
// Interrupt request flags, enables and interrupt pin of the reader frontend
// Behaviour
// - Flags A write: ones in bits 6-0 set if bit7 high, else clear
// - Flags B write: ones in bits 5-0 set if bit7 high, else clear
// - Flags A register resets to zero
// - FIFO high status rising sets latched flag A bit 6
// - FIFO low status rising sets latched flag A bit 5
// - Command ending by itself sets command-done flag bit 4
// - Unknown command returns field to idle and sets command-done flag
// - Host writing idle command sets no command-done flag
// - Last transmitted bit sets transmit-done flag bit 3
// - Receiver end of stream sets receive-done flag bit 2
// - Write, overflow, protocol, empty-send or integrity error sets error flag
// - Start of frame or subcarrier sets frame-start flag bit 0
// - Global flag set while any enabled request flag is set
// - Card detection sets card-detect flag, flags B bit 5
// - Timer underflows set flags B bits 4 to 0
// - Enable A bit 7 inverts interrupt output polarity
// - Enable A bits 6-0 pass matching flags A into global request
// - Enable B bits 5-0 pass matching flags B into global request
// - Enable B bit 6 gates global request onto interrupt pin
// - Enable B bit 7 selects push-pull, else open-drain
// - High status when FIFO size minus fill is at most water level
`timescale 1ns/1ps
`default_nettype none
module irqf_top (
  input  wire logic                   i_clock,
  input  wire logic                   i_reset_n,
  input  wire irqf_pkg::irqf_bus_type i_bus,
  output logic [7:0]                  o_rdata,
  input  wire logic                   i_cmd_known,
  input  wire logic                   i_cmd_finished,
  output logic [3:0]                  o_command,
  input  wire logic                   i_fifo_size_small,
  input  wire logic [9:0]             i_fifo_fill_count,
  input  wire logic [8:0]             i_water_level,
  output logic                        o_fifo_high_status,
  output logic                        o_fifo_low_status,
  input  wire logic                   i_transmit_done,
  input  wire logic                   i_receive_done,
  input  wire irqf_pkg::irqf_err_type i_errors,
  input  wire logic                   i_frame_start,
  input  wire logic                   i_card_detect,
  input  wire logic [4:0]             i_timer_underflow,
  output logic                        o_global_request,
  output irqf_pkg::irqf_pin_type      o_irq_pin
);
  irqf_pkg::irqf_regs_type regs_ff;
  irqf_pkg::irqf_regs_type nxt_regs;
  irqf_pkg::irqf_pin_type  pin_ff;
  irqf_pkg::irqf_pin_type  nxt_pin;
  logic       fifo_high_event;
  logic       fifo_low_event;
  logic       command_done_event;
  logic       error_event;
  logic       cmd_write;
  logic [7:0] hw_set_a;
  logic [7:0] hw_set_b;
  logic [7:0] sw_set_a;
  logic [7:0] sw_clr_a;
  logic [7:0] sw_set_b;
  logic [7:0] sw_clr_b;
  logic [7:0] flags_a_next;
  logic [7:0] flags_b_low;
  logic       global_next;
  logic       level;

  assign cmd_write = i_bus.wr && (i_bus.addr == irqf_pkg::COMMAND_OFFSET);

  irqf_fifo_alert u_fifo_alert (
    .i_clock            (i_clock),
    .i_reset_n          (i_reset_n),
    .i_size_small       (i_fifo_size_small),
    .i_fill_count       (i_fifo_fill_count),
    .i_water_level      (i_water_level),
    .o_fifo_high_status (o_fifo_high_status),
    .o_fifo_low_status  (o_fifo_low_status),
    .o_fifo_high_event  (fifo_high_event),
    .o_fifo_low_event   (fifo_low_event)
  );

  irqf_cmd_track u_cmd_track (
    .i_clock              (i_clock),
    .i_reset_n            (i_reset_n),
    .i_cmd_write          (cmd_write),
    .i_cmd_code           (i_bus.wdata[3:0]),
    .i_cmd_known          (i_cmd_known),
    .i_cmd_finished       (i_cmd_finished),
    .o_command            (o_command),
    .o_command_done_event (command_done_event)
  );

  assign error_event = i_errors.fifo_write_error | i_errors.fifo_overflow_error |
                       i_errors.protocol_error | i_errors.empty_send_error |
                       i_errors.integrity_error;

  always_comb
  begin
    hw_set_a = 8'h00;
    hw_set_a[irqf_pkg::FIFO_HIGH_BIT]   = fifo_high_event;
    hw_set_a[irqf_pkg::FIFO_LOW_BIT]    = fifo_low_event;
    hw_set_a[irqf_pkg::CMD_DONE_BIT]    = command_done_event;
    hw_set_a[irqf_pkg::TX_DONE_BIT]     = i_transmit_done;
    hw_set_a[irqf_pkg::RX_DONE_BIT]     = i_receive_done;
    hw_set_a[irqf_pkg::ERROR_BIT]       = error_event;
    hw_set_a[irqf_pkg::FRAME_START_BIT] = i_frame_start;
    hw_set_b = {3'h0, i_timer_underflow};
    hw_set_b[irqf_pkg::CARD_BIT] = i_card_detect;
  end

  always_comb
  begin
    sw_set_a = 8'h00;
    sw_clr_a = 8'h00;
    sw_set_b = 8'h00;
    sw_clr_b = 8'h00;
    if (i_bus.wr && i_bus.addr == irqf_pkg::FLAGS_A_OFFSET)
    begin
      // Only written ones act; zeros keep the flag
      if (i_bus.wdata[irqf_pkg::SET_BIT])
        sw_set_a = i_bus.wdata & irqf_pkg::A_FLAG_MASK;
      else
        sw_clr_a = i_bus.wdata & irqf_pkg::A_FLAG_MASK;
    end
    else if (i_bus.wr && i_bus.addr == irqf_pkg::FLAGS_B_OFFSET)
    begin
      // Global bit is derived, so only bits 5-0 are writable
      if (i_bus.wdata[irqf_pkg::SET_BIT])
        sw_set_b = i_bus.wdata & irqf_pkg::B_FLAG_MASK;
      else
        sw_clr_b = i_bus.wdata & irqf_pkg::B_FLAG_MASK;
    end
  end

  always_comb
  begin
    nxt_regs = regs_ff;
    // Hardware set wins over a same-cycle clear
    flags_a_next = ((regs_ff.flags_a & ~sw_clr_a) | sw_set_a | hw_set_a) &
                   irqf_pkg::A_FLAG_MASK;
    flags_b_low  = ((regs_ff.flags_b & ~sw_clr_b) | sw_set_b | hw_set_b) &
                   irqf_pkg::B_FLAG_MASK;
    if (i_bus.wr && i_bus.addr == irqf_pkg::ENABLE_A_OFFSET)
      nxt_regs.enable_a = i_bus.wdata;
    else if (i_bus.wr && i_bus.addr == irqf_pkg::ENABLE_B_OFFSET)
      nxt_regs.enable_b = i_bus.wdata;
    // Global from next flags and next enables
    global_next = |(flags_a_next & nxt_regs.enable_a & irqf_pkg::A_FLAG_MASK) |
                  |(flags_b_low & nxt_regs.enable_b & irqf_pkg::B_FLAG_MASK);
    nxt_regs.flags_a = flags_a_next;
    nxt_regs.flags_b = flags_b_low;
    nxt_regs.flags_b[irqf_pkg::GLOBAL_BIT] = global_next;
    // Read data; set bits read as zero
    if (!i_bus.rd)
      nxt_regs.rdata = regs_ff.rdata;
    else if (i_bus.addr == irqf_pkg::FLAGS_A_OFFSET)
      nxt_regs.rdata = regs_ff.flags_a & irqf_pkg::A_FLAG_MASK;
    else if (i_bus.addr == irqf_pkg::FLAGS_B_OFFSET)
      nxt_regs.rdata = regs_ff.flags_b & 8'h7F;
    else if (i_bus.addr == irqf_pkg::ENABLE_A_OFFSET)
      nxt_regs.rdata = regs_ff.enable_a;
    else if (i_bus.addr == irqf_pkg::ENABLE_B_OFFSET)
      nxt_regs.rdata = regs_ff.enable_b;
    else
      nxt_regs.rdata = 8'h00;
  end

  always_comb
  begin
    // Request level gated and polarity adjusted
    level = regs_ff.flags_b[irqf_pkg::GLOBAL_BIT] &
            regs_ff.enable_b[irqf_pkg::PIN_GATE_BIT];
    level = level ^ regs_ff.enable_a[irqf_pkg::INVERT_BIT];
    nxt_pin.pin = level;
    // Open drain releases the pin for a high level
    if (regs_ff.enable_b[irqf_pkg::DRIVE_SEL_BIT])
      nxt_pin.pin_oe_n = 1'b0;
    else
      nxt_pin.pin_oe_n = level;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      regs_ff.flags_a  <= irqf_pkg::FLAGS_A_RESET;
      regs_ff.flags_b  <= irqf_pkg::FLAGS_B_RESET;
      regs_ff.enable_a <= irqf_pkg::ENABLE_A_RESET;
      regs_ff.enable_b <= irqf_pkg::ENABLE_B_RESET;
      regs_ff.rdata    <= 8'h00;
      pin_ff           <= '{pin: 1'b0, pin_oe_n: 1'b1};
    end
    else
    begin
      regs_ff <= nxt_regs;
      pin_ff  <= nxt_pin;
    end
  end

  assign o_rdata          = regs_ff.rdata;
  assign o_global_request = regs_ff.flags_b[irqf_pkg::GLOBAL_BIT];
  assign o_irq_pin        = pin_ff;

  property p_reset_zero;
    @(posedge i_clock) $rose(i_reset_n) |-> regs_ff.flags_a == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags A not zero");

  property p_set_a;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_bus.wr && i_bus.addr == 8'h06 && i_bus.wdata[7] |=> (regs_ff.flags_a &
      $past(i_bus.wdata) & 8'h7F) == ($past(i_bus.wdata) & 8'h7F);
  endproperty
  a_set_a: assert property (p_set_a) else $error("flags A set failed");

  property p_clr_b;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_bus.wr && i_bus.addr == 8'h07 && !i_bus.wdata[7] && hw_set_b == 8'h00
      |=> (regs_ff.flags_b & $past(i_bus.wdata) & 8'h3F) == 8'h00;
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("flags B clear failed");

  property p_zero_keeps;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_bus.wr && i_bus.addr == 8'h06 |=>
      ((regs_ff.flags_a ^ $past(regs_ff.flags_a)) & ~$past(i_bus.wdata) &
      ~$past(hw_set_a) & 8'h7F) == 8'h00;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("unwritten flag changed");

  property p_hw_latch;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_transmit_done ##1 !(i_bus.wr && i_bus.addr == 8'h06) [*2] |->
      regs_ff.flags_a[3];
  endproperty
  a_hw_latch: assert property (p_hw_latch) else $error("transmit flag lost");

  property p_global;
    @(posedge i_clock) disable iff (!i_reset_n)
      o_global_request == (|(regs_ff.flags_a & regs_ff.enable_a & 8'h7F) |
      |(regs_ff.flags_b & regs_ff.enable_b & 8'h3F));
  endproperty
  a_global: assert property (p_global) else $error("global request mismatch");

  property p_pin_level;
    @(posedge i_clock) disable iff (!i_reset_n)
      ##1 o_irq_pin.pin == $past((o_global_request & regs_ff.enable_b[6]) ^
      regs_ff.enable_a[7]);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

  property p_open_drain;
    @(posedge i_clock) disable iff (!i_reset_n)
      !$past(regs_ff.enable_b[7]) && o_irq_pin.pin |-> o_irq_pin.pin_oe_n;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_no_idle_event;
    @(posedge i_clock) disable iff (!i_reset_n)
      cmd_write && i_bus.wdata[3:0] == 4'h0 |-> !command_done_event;
  endproperty
  a_no_idle_event: assert property (p_no_idle_event) else $error("idle write flagged");

  property p_fifo_high_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      $rose(o_fifo_high_status) |=> regs_ff.flags_a[6];
  endproperty
  a_fifo_high_set: assert property (p_fifo_high_set) else $error("high flag not set");

  property p_fifo_low_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      $rose(o_fifo_low_status) |=> regs_ff.flags_a[5];
  endproperty
  a_fifo_low_set: assert property (p_fifo_low_set) else $error("low flag not set");

  property p_flags_a_latched;
    @(posedge i_clock) disable iff (!i_reset_n)
      !(i_bus.wr && i_bus.addr == 8'h06) |=>
      (regs_ff.flags_a & $past(regs_ff.flags_a)) == $past(regs_ff.flags_a);
  endproperty
  a_flags_a_latched: assert property (p_flags_a_latched) else $error("flag A dropped");

  property p_cmd_done_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_cmd_finished && !cmd_write && o_command != 4'h0 |=>
      regs_ff.flags_a[4] && o_command == 4'h0;
  endproperty
  a_cmd_done_set: assert property (p_cmd_done_set) else $error("command end missed");

  property p_unknown_cmd;
    @(posedge i_clock) disable iff (!i_reset_n)
      cmd_write && i_bus.wdata[3:0] != 4'h0 && !i_cmd_known |=>
      regs_ff.flags_a[4] && o_command == 4'h0;
  endproperty
  a_unknown_cmd: assert property (p_unknown_cmd) else $error("unknown command kept");

  property p_rx_done_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_receive_done |=> regs_ff.flags_a[2];
  endproperty
  a_rx_done_set: assert property (p_rx_done_set) else $error("receive flag not set");

  property p_error_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|i_errors) |=> regs_ff.flags_a[1];
  endproperty
  a_error_set: assert property (p_error_set) else $error("error flag not set");

  property p_frame_start_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_frame_start |=> regs_ff.flags_a[0];
  endproperty
  a_frame_start_set: assert property (p_frame_start_set) else $error("frame flag not set");

  property p_card_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_card_detect |=> regs_ff.flags_b[5];
  endproperty
  a_card_set: assert property (p_card_set) else $error("card flag not set");

  property p_timer_set;
    @(posedge i_clock) disable iff (!i_reset_n)
      (|i_timer_underflow) |=>
      (regs_ff.flags_b[4:0] & $past(i_timer_underflow)) == $past(i_timer_underflow);
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer flag not set");

  property p_rd_bit7_zero;
    @(posedge i_clock) disable iff (!i_reset_n)
      i_bus.rd && (i_bus.addr == 8'h06 || i_bus.addr == 8'h07) |=> !o_rdata[7];
  endproperty
  a_rd_bit7_zero: assert property (p_rd_bit7_zero) else $error("bit 7 read back");

  property p_pin_gated;
    @(posedge i_clock) disable iff (!i_reset_n)
      !$past(regs_ff.enable_b[6]) |-> o_irq_pin.pin == $past(regs_ff.enable_a[7]);
  endproperty
  a_pin_gated: assert property (p_pin_gated) else $error("gated pin not idle");

  property p_push_pull;
    @(posedge i_clock) disable iff (!i_reset_n)
      $past(regs_ff.enable_b[7]) |-> !o_irq_pin.pin_oe_n;
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull not driving");

  c_global: cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(o_global_request));
  c_cmd: cover property (@(posedge i_clock) disable iff (!i_reset_n) command_done_event);
  c_card: cover property (@(posedge i_clock) disable iff (!i_reset_n) regs_ff.flags_b[5]);
  c_unknown: cover property (@(posedge i_clock) disable iff (!i_reset_n) cmd_write && !i_cmd_known);
  c_high: cover property (@(posedge i_clock) disable iff (!i_reset_n) $rose(o_fifo_high_status));
endmodule : irqf_top
`default_nettype wire

/* File: rtl/irqf_pkg.sv */
// Package of register map, field positions and carriers for the interrupt request flags
package irqf_pkg;
  localparam logic [7:0] FLAGS_A_OFFSET  = 8'h06;
  localparam logic [7:0] FLAGS_B_OFFSET  = 8'h07;
  localparam logic [7:0] ENABLE_A_OFFSET = 8'h08;
  localparam logic [7:0] ENABLE_B_OFFSET = 8'h09;
  localparam logic [7:0] COMMAND_OFFSET  = 8'h00;
  localparam logic [7:0] FLAGS_A_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_B_RESET   = 8'h00;
  localparam logic [7:0] ENABLE_A_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_B_RESET  = 8'h00;
  localparam int SET_BIT         = 7;
  localparam int FIFO_HIGH_BIT   = 6;
  localparam int FIFO_LOW_BIT    = 5;
  localparam int CMD_DONE_BIT    = 4;
  localparam int TX_DONE_BIT     = 3;
  localparam int RX_DONE_BIT     = 2;
  localparam int ERROR_BIT       = 1;
  localparam int FRAME_START_BIT = 0;
  localparam int GLOBAL_BIT      = 6;
  localparam int CARD_BIT        = 5;
  localparam int INVERT_BIT      = 7;
  localparam int PIN_GATE_BIT    = 6;
  localparam int DRIVE_SEL_BIT   = 7;
  localparam int TIMER_COUNT     = 5;
  localparam int A_FLAG_COUNT    = 7;
  localparam int B_FLAG_COUNT    = 6;
  localparam logic [7:0] A_FLAG_MASK = 8'h7F;
  localparam logic [7:0] B_FLAG_MASK = 8'h3F;
  localparam logic [3:0] CMD_IDLE    = 4'h0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } irqf_bus_type;

  typedef struct packed {
    logic                   fifo_write_error;
    logic                   fifo_overflow_error;
    logic                   protocol_error;
    logic                   empty_send_error;
    logic                   integrity_error;
  } irqf_err_type;

  typedef struct packed {
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] rdata;
  } irqf_regs_type;

  typedef struct packed {
    logic       high_prev;
    logic       low_prev;
  } irqf_edge_type;

  typedef struct packed {
    logic       pin;
    logic       pin_oe_n;
  } irqf_pin_type;

  typedef enum logic [1:0] {
    CMD_ST_IDLE,
    CMD_ST_RUN
  } irqf_cmd_state_type;

  typedef struct packed {
    irqf_cmd_state_type state;
    logic [3:0]         command;
  } irqf_cmd_type;
endpackage : irqf_pkg

/* File: rtl/irqf_fifo_alert.sv */
// FIFO high and low alert status with rising-edge events
`timescale 1ns/1ps
`default_nettype none
module irqf_fifo_alert (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_size_small,
  input  wire logic [9:0] i_fill_count,
  input  wire logic [8:0] i_water_level,
  output logic            o_fifo_high_status,
  output logic            o_fifo_low_status,
  output logic            o_fifo_high_event,
  output logic            o_fifo_low_event
);
  irqf_pkg::irqf_edge_type state_ff;
  irqf_pkg::irqf_edge_type nxt_state;
  logic [10:0] size_words;
  logic [10:0] room;
  logic [10:0] level;

  always_comb
  begin
    size_words = i_size_small ? 11'h0FF : 11'h200;
    level      = i_size_small ? {3'h0, i_water_level[7:0]} : {2'h0, i_water_level};
    room       = size_words - {1'h0, i_fill_count};
    o_fifo_high_status = (room <= level);
    o_fifo_low_status  = ({1'h0, i_fill_count} <= level);
    nxt_state.high_prev = o_fifo_high_status;
    nxt_state.low_prev  = o_fifo_low_status;
    o_fifo_high_event   = o_fifo_high_status & ~state_ff.high_prev;
    o_fifo_low_event    = o_fifo_low_status & ~state_ff.low_prev;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end
endmodule : irqf_fifo_alert
`default_nettype wire

/* File: rtl/irqf_cmd_track.sv */
// Command field tracker that flags self-terminated and unknown commands
`timescale 1ns/1ps
`default_nettype none
module irqf_cmd_track (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_cmd_write,
  input  wire logic [3:0] i_cmd_code,
  input  wire logic       i_cmd_known,
  input  wire logic       i_cmd_finished,
  output logic [3:0]      o_command,
  output logic            o_command_done_event
);
  irqf_pkg::irqf_cmd_type state_ff;
  irqf_pkg::irqf_cmd_type nxt_state;

  always_comb
  begin
    nxt_state            = state_ff;
    o_command_done_event = 1'b0;
    case (state_ff.state)
      irqf_pkg::CMD_ST_IDLE:
      begin
        if (i_cmd_write && i_cmd_code != irqf_pkg::CMD_IDLE)
        begin
          if (i_cmd_known)
          begin
            nxt_state.state   = irqf_pkg::CMD_ST_RUN;
            nxt_state.command = i_cmd_code;
          end
          else
            o_command_done_event = 1'b1;
        end
      end
      default:
      begin
        if (i_cmd_write && i_cmd_code == irqf_pkg::CMD_IDLE)
        begin
          // Host abort: no event
          nxt_state.state   = irqf_pkg::CMD_ST_IDLE;
          nxt_state.command = irqf_pkg::CMD_IDLE;
        end
        else if (i_cmd_write && !i_cmd_known)
        begin
          nxt_state.state      = irqf_pkg::CMD_ST_IDLE;
          nxt_state.command    = irqf_pkg::CMD_IDLE;
          o_command_done_event = 1'b1;
        end
        else if (i_cmd_write)
          nxt_state.command = i_cmd_code;
        else if (i_cmd_finished)
        begin
          nxt_state.state      = irqf_pkg::CMD_ST_IDLE;
          nxt_state.command    = irqf_pkg::CMD_IDLE;
          o_command_done_event = 1'b1;
        end
      end
    endcase
    o_command = state_ff.command;
  end

  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_ff <= '{state: irqf_pkg::CMD_ST_IDLE, command: irqf_pkg::CMD_IDLE};
    else
      state_ff <= nxt_state;
  end
endmodule : irqf_cmd_track
`default_nettype wire

/* File: testbench/irqf_host_model.sv */
// Host controller model: register bus master and interrupt pin observer
`timescale 1ns/1ps
`default_nettype none
module irqf_host_model (
  input  wire logic                   i_clock,
  input  wire logic [7:0]             i_rdata,
  input  wire irqf_pkg::irqf_pin_type i_irq_pin,
  output irqf_pkg::irqf_bus_type      o_bus,
  output logic                        o_pin_level
);
  // A released open-drain pin reads as the board pull-up
  assign o_pin_level = i_irq_pin.pin_oe_n ? 1'b1 : i_irq_pin.pin;

  initial o_bus = '0;

  // Idle bus after a write shows inverted address and data so stale values never match
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clock);
    o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
    @(negedge i_clock);
    o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
    d = i_rdata;
  endtask : read
endmodule : irqf_host_model
`default_nettype wire

/* File: testbench/tb_irqf_top.sv */
// Testbench of the interrupt request flags block
`timescale 1ns/1ps
`default_nettype none
module tb_irqf_top;
  logic                   clock;
  logic                   reset_n;
  irqf_pkg::irqf_bus_type bus;
  logic [7:0]             rdata;
  logic                   cmd_known;
  logic                   cmd_finished;
  logic [3:0]             command;
  logic                   size_small;
  logic [9:0]             fill;
  logic [8:0]             water;
  logic                   high_st;
  logic                   low_st;
  logic                   tx;
  logic                   rx;
  logic [4:0]             errs;
  logic                   sof;
  logic                   card;
  logic [4:0]             tmr;
  logic                   global_req;
  irqf_pkg::irqf_pin_type pin;
  logic                   pin_level;
  logic [7:0]             d;
  logic [7:0]             exp;
  int                     error_cnt;
  int                     tests_run;

  irqf_top uut (
    .i_clock(clock), .i_reset_n(reset_n), .i_bus(bus), .o_rdata(rdata),
    .i_cmd_known(cmd_known), .i_cmd_finished(cmd_finished), .o_command(command),
    .i_fifo_size_small(size_small), .i_fifo_fill_count(fill), .i_water_level(water),
    .o_fifo_high_status(high_st), .o_fifo_low_status(low_st), .i_transmit_done(tx),
    .i_receive_done(rx), .i_errors(irqf_pkg::irqf_err_type'(errs)), .i_frame_start(sof),
    .i_card_detect(card), .i_timer_underflow(tmr), .o_global_request(global_req),
    .o_irq_pin(pin)
  );

  irqf_host_model host (
    .i_clock(clock), .i_rdata(rdata), .i_irq_pin(pin), .o_bus(bus),
    .o_pin_level(pin_level)
  );

  always #25 clock = ~clock;

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic want);
    tests_run++;
    if (got !== want)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk_bit

  task automatic rchk(input logic [7:0] a, input logic [7:0] want);
    host.read(a, d);
    chk_byte(d, want);
  endtask : rchk

  task automatic drive_src(input int k, input logic v);
    if (k == 0)
      tx = v;
    else if (k == 1)
      rx = v;
    else if (k == 2)
      sof = v;
    else if (k < 8)
      errs[k-3] = v;
    else if (k == 8)
      card = v;
    else
      tmr[k-9] = v;
  endtask : drive_src

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end

  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    cmd_known = 1'b1;
    cmd_finished = 1'b0;
    size_small = 1'b1;
    fill = 10'h064;
    water = 9'h00A;
    tx = 1'b0;
    rx = 1'b0;
    errs = 5'h00;
    sof = 1'b0;
    card = 1'b0;
    tmr = 5'h00;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    $display("test reset done");
    host.write(8'h06, 8'hFF);
    rchk(8'h06, 8'h7F);
    host.write(8'h06, 8'h05);
    rchk(8'h06, 8'h7A);
    host.write(8'h06, 8'h80);
    rchk(8'h06, 8'h7A);
    host.write(8'h06, 8'h7F);
    rchk(8'h06, 8'h00);
    host.write(8'h07, 8'hFF);
    rchk(8'h07, 8'h3F);
    host.write(8'h07, 8'h3F);
    rchk(8'h07, 8'h00);
    host.write(8'h08, 8'h5A);
    rchk(8'h08, 8'h5A);
    host.write(8'h08, 8'h00);
    rchk(8'h0A, 8'h00);
    $display("test set_clear done");
    for (int k = 0; k < 14; k++)
    begin
      drive_src(k, 1'b1);
      @(negedge clock);
      drive_src(k, 1'b0);
      exp = (k == 0) ? 8'h08 : (k == 1) ? 8'h04 : (k == 2) ? 8'h01 : (k < 8) ? 8'h02 :
            (k == 8) ? 8'h20 : (8'h01 << (k - 9));
      rchk((k < 8) ? 8'h06 : 8'h07, exp);
      host.write((k < 8) ? 8'h06 : 8'h07, exp);
    end
    $display("test sources done");
    fill = 10'h0FA;
    @(negedge clock);
    chk_bit(high_st, 1'b1);
    fill = 10'h064;
    rchk(8'h06, 8'h40);
    fill = 10'h005;
    @(negedge clock);
    chk_bit(low_st, 1'b1);
    fill = 10'h064;
    rchk(8'h06, 8'h60);
    size_small = 1'b0;
    fill = 10'h1F9;
    @(negedge clock);
    chk_bit(high_st, 1'b1);
    water = 9'h10A;
    fill = 10'h0F6;
    @(negedge clock);
    chk_bit(high_st, 1'b1);
    chk_bit(low_st, 1'b1);
    fill = 10'h0F5;
    @(negedge clock);
    chk_bit(high_st, 1'b0);
    water = 9'h00A;
    fill = 10'h064;
    size_small = 1'b1;
    host.write(8'h06, 8'h7F);
    rchk(8'h06, 8'h00);
    $display("test fifo done");
    host.write(8'h00, 8'h03);
    chk_byte({4'h0, command}, 8'h03);
    cmd_finished = 1'b1;
    @(negedge clock);
    cmd_finished = 1'b0;
    rchk(8'h06, 8'h10);
    chk_byte({4'h0, command}, 8'h00);
    host.write(8'h06, 8'h10);
    cmd_known = 1'b0;
    host.write(8'h00, 8'h05);
    rchk(8'h06, 8'h10);
    chk_byte({4'h0, command}, 8'h00);
    host.write(8'h06, 8'h10);
    cmd_known = 1'b1;
    host.write(8'h00, 8'h03);
    host.write(8'h00, 8'h00);
    rchk(8'h06, 8'h00);
    chk_byte({4'h0, command}, 8'h00);
    $display("test command done");
    host.write(8'h08, 8'h08);
    host.write(8'h06, 8'h88);
    rchk(8'h07, 8'h40);
    chk_bit(global_req, 1'b1);
    chk_bit(pin_level, 1'b0);
    host.write(8'h09, 8'hC0);
    repeat (2) @(negedge clock);
    chk_byte({6'h00, pin}, 8'h02);
    host.write(8'h08, 8'h88);
    repeat (2) @(negedge clock);
    chk_byte({6'h00, pin}, 8'h00);
    host.write(8'h09, 8'h40);
    repeat (2) @(negedge clock);
    chk_bit(pin_level, 1'b0);
    host.write(8'h08, 8'h08);
    repeat (2) @(negedge clock);
    chk_byte({6'h00, pin}, 8'h03);
    chk_bit(pin_level, 1'b1);
    host.write(8'h08, 8'h00);
    rchk(8'h07, 8'h00);
    chk_bit(global_req, 1'b0);
    host.write(8'h07, 8'h81);
    host.write(8'h09, 8'h41);
    rchk(8'h07, 8'h41);
    host.write(8'h09, 8'h40);
    rchk(8'h07, 8'h01);
    $display("test global done");
    host.write(8'h06, 8'hFF);
    host.write(8'h08, 8'h7F);
    chk_bit(global_req, 1'b1);
    reset_n = 1'b0;
    @(negedge clock);
    chk_bit(global_req, 1'b0);
    chk_byte({6'h00, pin}, 8'h01);
    reset_n = 1'b1;
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h08, 8'h00);
    $display("test mid reset done");
    final_report();
  end
endmodule : tb_irqf_top
`default_nettype wire
